// ### verif/icp_dev_model.sv
// Behavioural device: command-port slave, status replies, init flag
`timescale 1ns/1ps
module icp_dev_model (
	input wire logic clk_sys,
	input wire logic rstN,
	input wire logic scl,
	input wire logic sda,
	output logic sdaPull,
	output logic initFlag
);
	import icp_pkg::*;
	int readyAfter = 0;
	int errPulses = 0;
	int polls = 0;
	int nLog = 0;
	int ev;
	int i;
	logic errBit = 1'b0;
	logic nackAll = 1'b0;
	logic ok;
	logic [7:0] v;
	logic [7:0] byteLog [16];
	// ----------------------------------------------------------------
	// Bit and byte handling; a change of SDA with SCL high ends a byte
	// ----------------------------------------------------------------
	task automatic getBit(output int b);
		@(posedge scl);
		b = int'(sda);
		@(negedge scl or sda);
		if (scl) b = sda ? 2 : 3;
	endtask
	task automatic getByte(output logic [7:0] d, output int e);
		int b;
		e = 0;
		d = 8'h00;
		for (int k = 0; k < 8 && e == 0; k++) begin
			getBit(b);
			if (b > 1) e = b;
			d = {d[6:0], b[0]};
		end
		if (e == 0 && nLog < 16) byteLog[nLog] = d;
		if (e == 0) nLog++;
	endtask
	task automatic ackBit();
		sdaPull = 1'b1;
		@(posedge scl);
		@(negedge scl);
		sdaPull = 1'b0;
	endtask
	task automatic sendByte(input logic [7:0] d, output logic acked);
		for (int k = 7; k >= 0; k--) begin
			sdaPull = !d[k];
			@(posedge scl);
			@(negedge scl);
		end
		sdaPull = 1'b0;
		@(posedge scl);
		acked = !sda;
		@(negedge scl);
	endtask
	initial begin
		sdaPull = 1'b0;
		forever begin
			@(negedge sda iff scl === 1'b1);
			getByte(v, ev);
			if (ev == 0 && !initFlag && !nackAll && (v == DEV_WRITE_ADDR || v == DEV_READ_ADDR)) begin
				ackBit();
				if (v == DEV_READ_ADDR) begin
					polls++;
					sendByte({6'h00, errBit, polls > readyAfter}, ok);
					for (i = 0; ok; i++) sendByte(polls > readyAfter ? 8'h5a + 8'(i) : 8'hee, ok);
				end else begin
					while (ev == 0) begin
						getByte(v, ev);
						if (ev == 0) ackBit();
					end
				end
			end
		end
	end
	// Flag rises soon after reset release; error pulses follow the init period
	initial begin
		initFlag = 1'b0;
		forever begin
			@(posedge rstN);
			repeat (50) @(posedge clk_sys);
			initFlag <= 1'b1;
			repeat (300) @(posedge clk_sys);
			initFlag <= 1'b0;
			repeat (errPulses) begin
				repeat (40) @(posedge clk_sys);
				initFlag <= 1'b1;
				repeat (20) @(posedge clk_sys);
				initFlag <= 1'b0;
			end
		end
	end
endmodule

// ### verif/icp_host_sva.sv
// Port assertions for the command-port host controller
`timescale 1ns/1ps
module icp_host_sva (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic initFlagPin,
	input wire logic activeLowResetPinN
);
	import icp_pkg::*;
	// ----------------------------------------------------------------
	// Helper state: SCL low length and init progress seen at the pin
	// ----------------------------------------------------------------
	logic [7:0] lowCnt_q, lowCnt_d;
	logic rose_q, rose_d, done_q, done_d;
	always_comb begin
		lowCnt_d = (sclOe && lowCnt_q != 8'hff) ? lowCnt_q + 8'h01 : (sclOe ? lowCnt_q : 8'h00);
		rose_d = rose_q | initFlagPin;
		done_d = done_q | (rose_q & !initFlagPin);
		if (wrStrobe && addr == REG_CTRL && wrData[CTRL_HOLD]) begin
			rose_d = 1'b0;
			done_d = 1'b0;
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lowCnt_q <= 8'h00;
			rose_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			lowCnt_q <= lowCnt_d;
			rose_q <= rose_d;
			done_q <= done_d;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_hold_wr;
		wrStrobe && addr == REG_CTRL && wrData[CTRL_HOLD];
	endsequence
	sequence s_free_wr;
		wrStrobe && addr == REG_CTRL && !wrData[CTRL_HOLD];
	endsequence
	a_rd_only_after: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
		else $error("read data outside its cycle");
	a_ctrl_reads_zero: assert property (rdStrobe && addr == REG_CTRL |=> rdData == 8'h00)
		else $error("control register read not zero");
	a_unmapped_zero: assert property (rdStrobe && addr > REG_REPLY |=> rdData == 8'h00)
		else $error("unmapped read not zero");
	a_open_drain: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
		else $error("bus drive value not low");
	a_hold_pin_low: assert property (s_hold_wr |=> ##1 !activeLowResetPinN [*2])
		else $error("device reset not held");
	a_free_pin_high: assert property (s_free_wr |=> ##1 activeLowResetPinN)
		else $error("device reset not released");
	a_init_quiet: assert property (!done_q |-> !sclOe && !sdaOe)
		else $error("bus driven before init done");
	a_scl_low_len: assert property ($fell(sclOe) |-> lowCnt_q >= 8'h64)
		else $error("bus clock low phase too short");
endmodule

// ### verif/icp_host_test.sv
// Self-checking bench for the command-port host controller
`timescale 1ns/1ps
module icp_host_test;
	import icp_pkg::*;
	localparam int TIMEOUT_CYCLES = 90000;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic [7:0] rdData, v;
	logic [7:0] expQ [$];
	logic sclOut, sclOe, sdaOut, sdaOe, sdaPull, initFlagPin, activeLowResetPinN;
	int badCount = 0;
	int numChecks = 0;
	int cycles = 0;
	// Open-drain wires with pull-ups
	wire sclWire = !sclOe;
	wire sdaWire = !(sdaOe || sdaPull);
	always #5 clk_sys = !clk_sys;
	icp_host #(.INIT_RISE_LIMIT(200)) u_icp_host (.clk_sys(clk_sys), .reset(reset), .addr(addr),
		.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .sclIn(sclWire),
		.sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.initFlagPin(initFlagPin), .activeLowResetPinN(activeLowResetPinN));
	icp_dev_model u_icp_dev_model (.clk_sys(clk_sys), .rstN(activeLowResetPinN), .scl(sclWire),
		.sda(sdaWire), .sdaPull(sdaPull), .initFlag(initFlagPin));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stopTest();
		if (badCount == 0 && numChecks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] got);
		numChecks++;
		if (got !== e) begin
			$display("MISMATCH %s expected %h seen %h", name, e, got);
			badCount++;
		end
	endtask
	task automatic chkLog(input string name);
		chk(name, 8'(expQ.size()), 8'(u_icp_dev_model.nLog));
		foreach (expQ[k]) chk(name, expQ[k], u_icp_dev_model.byteLog[k]);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clk_sys);
		wrStrobe <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk_sys);
		rdStrobe <= 1'b0;
		#1 d = rdData;
		@(posedge clk_sys);
	endtask
	task automatic runCmd(input logic [7:0] ctrl);
		int n;
		u_icp_dev_model.nLog = 0;
		wr(REG_CTRL, ctrl);
		rd(REG_STATUS, v);
		for (n = 0; n < 20000 && v[0] === 1'b1; n++) rd(REG_STATUS, v);
		chk("command done", 8'h00, {7'h00, v[0]});
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic testInit();
		int n;
		for (n = 0; n < 200 && initFlagPin !== 1'b1; n++) @(posedge clk_sys);
		wr(REG_CTRL, 8'h01);
		rd(REG_STATUS, v);
		chk("busy during init", 8'h00, {7'h00, v[0]});
		for (n = 0; n < 1000 && initFlagPin !== 1'b0; n++) @(posedge clk_sys);
		repeat (10) @(posedge clk_sys);
		rd(REG_STATUS, v);
		chk("init status", 8'h02, v & 8'h23);
		rd(4'hc, v);
		chk("unmapped read", 8'h00, v);
	endtask
	task automatic testWrite();
		wr(REG_CMD, 8'h12);
		wr(REG_LEN, 8'h04);
		for (int i = 0; i < 4; i++) wr(4'(4 + i), 8'ha1 + 8'(i));
		runCmd(8'h01);
		expQ = {DEV_WRITE_ADDR, 8'h12 | WRITE_FLAG, 8'ha1, 8'ha2, 8'ha3, 8'ha4};
		chkLog("write frame");
	endtask
	task automatic testExtRead();
		u_icp_dev_model.readyAfter = 1;
		u_icp_dev_model.errBit = 1'b1;
		wr(REG_EXT, 8'h2a);
		wr(REG_LEN, 8'h02);
		runCmd(8'h06);
		expQ = {DEV_WRITE_ADDR, ESCAPE_CODE, 8'h2a, DEV_READ_ADDR, DEV_READ_ADDR};
		chkLog("extended read frames");
		rd(REG_REPLY, v);
		chk("reply byte", 8'h03, v);
		rd(REG_STATUS, v);
		chk("device flags", 8'h18, v & 8'h1c);
		rd(4'h4, v);
		chk("read data 0", 8'h5a, v);
		rd(4'h5, v);
		chk("read data 1", 8'h5b, v);
		u_icp_dev_model.errBit = 1'b0;
	endtask
	task automatic testStandbyNack();
		runCmd(8'h08);
		expQ = {DEV_WRITE_ADDR, STANDBY_CMD | WRITE_FLAG, STANDBY_VALUE};
		chkLog("standby frame");
		u_icp_dev_model.nackAll = 1'b1;
		runCmd(8'h02);
		expQ = {DEV_WRITE_ADDR};
		chkLog("refused frame");
		rd(REG_STATUS, v);
		chk("nack flag", 8'h04, v & 8'h05);
		u_icp_dev_model.nackAll = 1'b0;
	endtask
	task automatic testHold();
		u_icp_dev_model.errPulses = 2;
		wr(REG_CTRL, 8'h10);
		@(negedge clk_sys);
		chk("device reset held", 8'h00, {7'h00, activeLowResetPinN});
		repeat (10) @(posedge clk_sys);
		wr(REG_CTRL, 8'h00);
		// Flag period plus two error pulses fit well inside this wait
		repeat (800) @(posedge clk_sys);
		rd(REG_STATUS, v);
		chk("init pulse count", 8'h82, v & 8'hc2);
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == TIMEOUT_CYCLES) begin
			badCount++;
			stopTest();
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		testInit();
		testWrite();
		testExtRead();
		testStandbyNack();
		testHold();
		stopTest();
	end
endmodule
bind icp_host icp_host_sva u_icp_host_sva (.clk_sys(clk_sys), .reset(reset), .addr(addr),
	.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .sclOut(sclOut),
	.sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .initFlagPin(initFlagPin),
	.activeLowResetPinN(activeLowResetPinN));

// ### verilog/icp_host.sv
// Host controller that drives the formatter command port and watches its init flag
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module icp_host #(
	parameter int INIT_RISE_LIMIT = icp_pkg::INIT_RISE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic initFlagPin,
	output logic activeLowResetPinN
);
	import icp_pkg::*;

	typedef enum {P_IDLE, P_WSTART, P_WADDR, P_WCMD, P_WEXT, P_WDATA, P_WSTOP,
		P_RSTART, P_RADDR, P_RSTAT, P_RDATA, P_RSTOP} icp_phase_type;
	typedef enum {I_WAIT_RISE, I_WAIT_FALL, I_RUN} icp_init_type;

	localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_RISE_LIMIT - 1);

	logic sclSync, sdaSync, flagSync;
	logic opDone, ackSeen, engSclOe, engSdaOe;
	logic [7:0] rxByte;

	icp_sync #(.WIDTH(3)) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.d({sclIn, sdaIn, initFlagPin}),
		.q({sclSync, sdaSync, flagSync})
	);

	// ----------------------------------------------------------------
	// Init flag tracking and device reset pin
	// ----------------------------------------------------------------
	icp_init_type init_q, init_d;
	logic [INIT_CNT_W-1:0] initCnt_q, initCnt_d;
	logic initMissing_q, initMissing_d;
	logic [1:0] pulses_q, pulses_d;
	logic flagPrev_q, flagPrev_d;
	logic hold_q, hold_d;
	logic resetPin_q, resetPin_d;
	logic initDone;

	always_comb begin
		init_d = init_q;
		initCnt_d = initCnt_q;
		initMissing_d = initMissing_q;
		pulses_d = pulses_q;
		flagPrev_d = flagSync;
		resetPin_d = !hold_q;
		if (hold_q) begin
			init_d = I_WAIT_RISE;
			initCnt_d = '0;
			initMissing_d = 1'b0;
			pulses_d = 2'd0;
		end else begin
			case (init_q)
				I_WAIT_RISE: begin
					if (flagSync) begin
						init_d = I_WAIT_FALL;
					end else if (initCnt_q == INIT_LAST) begin
						initMissing_d = 1'b1;
					end else begin
						initCnt_d = initCnt_q + 1'b1;
					end
				end
				I_WAIT_FALL: begin
					if (!flagSync) begin
						init_d = I_RUN;
					end
				end
				I_RUN: begin
					// Late pulses report init errors; two mean a memory test failure
					if (flagSync && !flagPrev_q && pulses_q != PULSE_MAX) begin
						pulses_d = pulses_q + 1'b1;
					end
				end
				default: init_d = I_WAIT_RISE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			init_q <= I_WAIT_RISE;
			initCnt_q <= '0;
			initMissing_q <= 1'b0;
			pulses_q <= 2'd0;
			flagPrev_q <= 1'b0;
			resetPin_q <= 1'b0;
		end else begin
			init_q <= init_d;
			initCnt_q <= initCnt_d;
			initMissing_q <= initMissing_d;
			pulses_q <= pulses_d;
			flagPrev_q <= flagPrev_d;
			resetPin_q <= resetPin_d;
		end
	end

	assign initDone = (init_q == I_RUN);

	// ----------------------------------------------------------------
	// Command sequencer and software registers
	// ----------------------------------------------------------------
	icp_phase_type phase_q, phase_d;
	logic pend_q, pend_d;
	logic opValid_q, opValid_d;
	icp_op_type opCode_q, opCode_d;
	logic [7:0] txByte_q, txByte_d;
	logic ackSend_q, ackSend_d;
	logic [7:0] cmd_q, cmd_d;
	logic [7:0] ext_q, ext_d;
	logic [LEN_W-1:0] len_q, len_d;
	logic [7:0] data_q [DATA_BYTES];
	logic [7:0] data_d [DATA_BYTES];
	logic [LEN_W-1:0] idx_q, idx_d;
	logic isRead_q, isRead_d;
	logic useExt_q, useExt_d;
	logic abort_q, abort_d;
	logic nack_q, nack_d;
	logic [7:0] devStat_q, devStat_d;
	logic [7:0] rdData_q, rdData_d;
	logic busy;
	logic devReady;
	logic [LEN_W-1:0] lenLast;

	assign busy = (phase_q != P_IDLE);
	assign devReady = devStat_q[STAT_READY_BIT];
	assign lenLast = len_q - LEN_ONE;

	always_comb begin
		phase_d = phase_q;
		pend_d = pend_q;
		opValid_d = 1'b0;
		opCode_d = opCode_q;
		txByte_d = txByte_q;
		ackSend_d = ackSend_q;
		cmd_d = cmd_q;
		ext_d = ext_q;
		len_d = len_q;
		data_d = data_q;
		idx_d = idx_q;
		isRead_d = isRead_q;
		useExt_d = useExt_q;
		abort_d = abort_q;
		nack_d = nack_q;
		devStat_d = devStat_q;
		hold_d = hold_q;
		rdData_d = 8'h00;

		// Software writes; command fields are frozen while a transfer runs
		if (wrStrobe) begin
			if (addr == REG_CTRL) begin
				hold_d = wrData[CTRL_HOLD];
				// Launch only once init is over and the last command has finished
				if (!busy && initDone && !hold_q && (wrData[CTRL_WRITE] || wrData[CTRL_READ] ||
						wrData[CTRL_STANDBY])) begin
					phase_d = P_WSTART;
					idx_d = '0;
					abort_d = 1'b0;
					nack_d = 1'b0;
					isRead_d = wrData[CTRL_READ] && !wrData[CTRL_WRITE] && !wrData[CTRL_STANDBY];
					useExt_d = wrData[CTRL_EXT] && !wrData[CTRL_STANDBY];
					if (wrData[CTRL_STANDBY]) begin
						cmd_d = STANDBY_CMD;
						data_d[0] = STANDBY_VALUE;
						len_d = LEN_ONE;
					end
				end
			end else if (!busy) begin
				if (addr == REG_CMD) begin
					cmd_d = wrData;
				end else if (addr == REG_EXT) begin
					ext_d = wrData;
				end else if (addr == REG_LEN) begin
					len_d = (wrData > 8'(LEN_MAX)) ? LEN_MAX : wrData[LEN_W-1:0];
				end else if (addr[3:2] == REG_DATA_PAGE) begin
					data_d[addr[1:0]] = wrData;
				end
			end
		end

		// Software reads, answered in the next cycle
		if (rdStrobe) begin
			if (addr == REG_CMD) begin
				rdData_d = cmd_q;
			end else if (addr == REG_EXT) begin
				rdData_d = ext_q;
			end else if (addr == REG_LEN) begin
				rdData_d = 8'(len_q);
			end else if (addr[3:2] == REG_DATA_PAGE) begin
				rdData_d = data_q[addr[1:0]];
			end else if (addr == REG_STATUS) begin
				rdData_d = {pulses_q, initMissing_q, devStat_q[STAT_ERROR_BIT], devReady, nack_q,
					initDone, busy};
			end else if (addr == REG_REPLY) begin
				rdData_d = devStat_q;
			end
		end

		// Issue one engine operation at a time; the data phases issue one per byte
		if (busy && !pend_q) begin
			pend_d = 1'b1;
			opValid_d = 1'b1;
			opCode_d = OP_WRITE;
			ackSend_d = 1'b0;
			case (phase_q)
				P_WSTART, P_RSTART: opCode_d = OP_START;
				P_WSTOP, P_RSTOP: opCode_d = OP_STOP;
				P_WADDR: txByte_d = DEV_WRITE_ADDR;
				P_WCMD: begin
					if (useExt_q) begin
						txByte_d = ESCAPE_CODE;
					end else if (isRead_q) begin
						txByte_d = cmd_q;
					end else begin
						txByte_d = cmd_q | WRITE_FLAG;
					end
				end
				P_WEXT: txByte_d = ext_q;
				P_WDATA: txByte_d = data_q[idx_q[1:0]];
				P_RADDR: txByte_d = DEV_READ_ADDR;
				P_RSTAT: begin
					opCode_d = OP_READ;
					ackSend_d = (len_q != '0);
				end
				default: begin
					opCode_d = OP_READ;
					ackSend_d = (idx_q != lenLast);
				end
			endcase
		end

		// Advance when the engine finishes
		if (busy && pend_q && opDone) begin
			pend_d = 1'b0;
			case (phase_q)
				P_WSTART: phase_d = P_WADDR;
				P_WADDR, P_WCMD, P_WEXT, P_WDATA: begin
					if (ackSeen != BUS_ACK) begin
						nack_d = 1'b1;
						abort_d = 1'b1;
						phase_d = P_WSTOP;
					end else if (phase_q == P_WADDR) begin
						phase_d = P_WCMD;
					end else if (phase_q == P_WCMD && useExt_q) begin
						phase_d = P_WEXT;
					end else if (phase_q == P_WDATA) begin
						if (idx_q == lenLast) begin
							phase_d = P_WSTOP;
						end else begin
							idx_d = idx_q + 1'b1;
						end
					end else if (!isRead_q && len_q != '0) begin
						phase_d = P_WDATA;
					end else begin
						phase_d = P_WSTOP;
					end
				end
				P_WSTOP: phase_d = (isRead_q && !abort_q) ? P_RSTART : P_IDLE;
				P_RSTART: phase_d = P_RADDR;
				P_RADDR: begin
					if (ackSeen != BUS_ACK) begin
						nack_d = 1'b1;
						abort_d = 1'b1;
						phase_d = P_RSTOP;
					end else begin
						phase_d = P_RSTAT;
					end
				end
				P_RSTAT: begin
					devStat_d = rxByte;
					idx_d = '0;
					phase_d = (len_q == '0) ? P_RSTOP : P_RDATA;
				end
				P_RDATA: begin
					if (devReady) begin
						data_d[idx_q[1:0]] = rxByte;
					end
					if (idx_q == lenLast) begin
						phase_d = P_RSTOP;
					end else begin
						idx_d = idx_q + 1'b1;
					end
				end
				P_RSTOP: phase_d = (abort_q || devReady) ? P_IDLE : P_RSTART;
				default: phase_d = P_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase_q <= P_IDLE;
			pend_q <= 1'b0;
			opValid_q <= 1'b0;
			opCode_q <= OP_START;
			txByte_q <= 8'h00;
			ackSend_q <= 1'b0;
			cmd_q <= 8'h00;
			ext_q <= 8'h00;
			len_q <= '0;
			data_q <= '{default: 8'h00};
			idx_q <= '0;
			isRead_q <= 1'b0;
			useExt_q <= 1'b0;
			abort_q <= 1'b0;
			nack_q <= 1'b0;
			devStat_q <= 8'h00;
			hold_q <= 1'b0;
			rdData_q <= 8'h00;
		end else begin
			phase_q <= phase_d;
			pend_q <= pend_d;
			opValid_q <= opValid_d;
			opCode_q <= opCode_d;
			txByte_q <= txByte_d;
			ackSend_q <= ackSend_d;
			cmd_q <= cmd_d;
			ext_q <= ext_d;
			len_q <= len_d;
			data_q <= data_d;
			idx_q <= idx_d;
			isRead_q <= isRead_d;
			useExt_q <= useExt_d;
			abort_q <= abort_d;
			nack_q <= nack_d;
			devStat_q <= devStat_d;
			hold_q <= hold_d;
			rdData_q <= rdData_d;
		end
	end

	// ----------------------------------------------------------------
	// Bit engine, clocked no faster than the bus limit
	// ----------------------------------------------------------------
	icp_i2c_bit u_bit (
		.clk_sys(clk_sys),
		.reset(reset),
		.opValid(opValid_q),
		.opCode(opCode_q),
		.txByte(txByte_q),
		.ackSend(ackSend_q),
		.sclIn(sclSync),
		.sdaIn(sdaSync),
		.opDone(opDone),
		.rxByte(rxByte),
		.ackSeen(ackSeen),
		.sclOe(engSclOe),
		.sdaOe(engSdaOe)
	);

	assign rdData = rdData_q;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = engSclOe;
	assign sdaOe = engSdaOe;
	assign activeLowResetPinN = resetPin_q;
endmodule

// ### verilog/icp_i2c_bit.sv
// Bus bit engine: start, stop, and 9-bit byte transfers with clock stretching
`timescale 1ns/1ps
module icp_i2c_bit (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic opValid,
	input wire icp_pkg::icp_op_type opCode,
	input wire logic [7:0] txByte,
	input wire logic ackSend,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic opDone,
	output logic [7:0] rxByte,
	output logic ackSeen,
	output logic sclOe,
	output logic sdaOe
);
	import icp_pkg::*;

	typedef enum logic [1:0] {B_IDLE, B_START, B_BIT, B_STOP} icp_bit_state_type;

	icp_bit_state_type state_q, state_d;
	logic [1:0] step_q, step_d;
	logic [QCNT_W-1:0] qCnt_q, qCnt_d;
	logic [3:0] bitIdx_q, bitIdx_d;
	logic [8:0] tx_q, tx_d;
	logic [8:0] rx_q, rx_d;
	logic sclOe_q, sclOe_d;
	logic sdaOe_q, sdaOe_d;
	logic done_q, done_d;
	logic stretch;
	logic tick;

	// ----------------------------------------------------------------
	// Quarter-bit sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		step_d = step_q;
		bitIdx_d = bitIdx_q;
		tx_d = tx_q;
		rx_d = rx_q;
		sclOe_d = sclOe_q;
		sdaOe_d = sdaOe_q;
		done_d = 1'b0;
		// Released clock held low by the far end keeps the quarter timer at zero
		stretch = !sclOe_q && !sclIn;
		tick = (qCnt_q == QUARTER_LAST) && !stretch;
		if (state_q == B_IDLE || stretch || tick) begin
			qCnt_d = '0;
		end else begin
			qCnt_d = qCnt_q + 1'b1;
		end
		case (state_q)
			B_IDLE: begin
				if (opValid) begin
					step_d = 2'd0;
					bitIdx_d = 4'd0;
					rx_d = '0;
					case (opCode)
						OP_START: begin
							state_d = B_START;
							sclOe_d = 1'b0;
							sdaOe_d = 1'b0;
						end
						OP_STOP: begin
							state_d = B_STOP;
							sclOe_d = 1'b1;
							sdaOe_d = 1'b1;
						end
						OP_WRITE: begin
							state_d = B_BIT;
							tx_d = {txByte, 1'b1};
							sclOe_d = 1'b1;
						end
						default: begin
							state_d = B_BIT;
							tx_d = {8'hff, !ackSend};
							sclOe_d = 1'b1;
						end
					endcase
				end
			end
			B_START: begin
				if (tick) begin
					step_d = step_q + 1'b1;
					case (step_q)
						2'd0: sdaOe_d = 1'b1;
						2'd1: sclOe_d = 1'b1;
						default: begin
							done_d = 1'b1;
							state_d = B_IDLE;
						end
					endcase
				end
			end
			B_STOP: begin
				if (tick) begin
					step_d = step_q + 1'b1;
					case (step_q)
						2'd0: sclOe_d = 1'b1;
						2'd1: sclOe_d = 1'b0;
						2'd2: sdaOe_d = 1'b0;
						default: begin
							done_d = 1'b1;
							state_d = B_IDLE;
						end
					endcase
				end
			end
			B_BIT: begin
				if (tick) begin
					step_d = step_q + 1'b1;
					case (step_q)
						2'd0: begin
							// Data moves a quarter bit after the clock went low
							sdaOe_d = !tx_q[8];
						end
						2'd1: sclOe_d = 1'b0;
						2'd2: rx_d = {rx_q[7:0], sdaIn};
						default: begin
							// Clock pulled low; data holds until the next quarter
							sclOe_d = 1'b1;
							if (bitIdx_q == 4'd8) begin
								done_d = 1'b1;
								state_d = B_IDLE;
							end else begin
								bitIdx_d = bitIdx_q + 1'b1;
								tx_d = {tx_q[7:0], 1'b1};
							end
						end
					endcase
				end
			end
			default: state_d = B_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= B_IDLE;
			step_q <= 2'd0;
			qCnt_q <= '0;
			bitIdx_q <= 4'd0;
			tx_q <= '1;
			rx_q <= '0;
			sclOe_q <= 1'b0;
			sdaOe_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			step_q <= step_d;
			qCnt_q <= qCnt_d;
			bitIdx_q <= bitIdx_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			sclOe_q <= sclOe_d;
			sdaOe_q <= sdaOe_d;
			done_q <= done_d;
		end
	end

	assign opDone = done_q;
	assign rxByte = rx_q[8:1];
	assign ackSeen = rx_q[0];
	assign sclOe = sclOe_q;
	assign sdaOe = sdaOe_q;
endmodule

// ### verilog/icp_pkg.sv
// Shared constants and types for the command-port host controller
package icp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_MIN_PERIOD_NS = 2500;
	localparam int QUARTER_CYCLES = (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
	localparam int QCNT_W = 7;
	localparam logic [QCNT_W-1:0] QUARTER_LAST = QCNT_W'(QUARTER_CYCLES - 1);
	localparam int INIT_RISE_TIME_US = 5000;
	localparam int INIT_RISE_CYCLES = (INIT_RISE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int INIT_CNT_W = 20;

	// ----------------------------------------------------------------
	// Command bus framing
	// ----------------------------------------------------------------
	localparam logic [7:0] DEV_WRITE_ADDR = 8'h34;
	localparam logic [7:0] DEV_READ_ADDR = 8'h35;
	localparam logic [7:0] ESCAPE_CODE = 8'h01;
	localparam logic [7:0] WRITE_FLAG = 8'h80;
	localparam logic [7:0] STANDBY_CMD = 8'h07;
	localparam logic [7:0] STANDBY_VALUE = 8'h01;
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_ERROR_BIT = 1;
	localparam logic BUS_ACK = 1'b0;

	// ----------------------------------------------------------------
	// Software register map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h1;
	localparam logic [3:0] REG_EXT = 4'h2;
	localparam logic [3:0] REG_LEN = 4'h3;
	localparam logic [1:0] REG_DATA_PAGE = 2'h1;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_REPLY = 4'h9;
	localparam int CTRL_WRITE = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_EXT = 2;
	localparam int CTRL_STANDBY = 3;
	localparam int CTRL_HOLD = 4;
	localparam int DATA_BYTES = 4;
	localparam int LEN_W = 3;
	localparam logic [LEN_W-1:0] LEN_MAX = 3'h4;
	localparam logic [LEN_W-1:0] LEN_ONE = 3'h1;
	localparam logic [1:0] PULSE_MAX = 2'h3;

	typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} icp_op_type;

endpackage

// ### verilog/icp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module icp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	import icp_pkg::*;

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			// Clear low so the init flag shows no false rise after reset
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule
